/* bench/port_pin_board.sv */
// Board-side model of the port pins seen by the stop wake block
`timescale 1ns/100ps
module port_pin_board (
	input  wire logic [7:0] port2_pin_out,
	input  wire logic [7:0] port2_pin_oe,
	input  wire logic [7:0] board_port2,
	input  wire logic [3:0] board_p3,
	input  wire logic       board_port0_pin0,
	input  wire logic       board_port0_pin7,
	output logic      [7:0] port2_pin_in,
	output logic      [3:0] port3_pin_in,
	output logic            port0_pin0_in,
	output logic            port0_pin7_in
);
	// Driven pins show the block's latch, the others the board level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			port2_pin_in[i] = port2_pin_oe[i] ? port2_pin_out[i] : board_port2[i];
		end
	end
	assign port3_pin_in  = board_p3;
	assign port0_pin0_in = board_port0_pin0;
	assign port0_pin7_in = board_port0_pin7;
endmodule // port_pin_board

/* bench/stop_wake_event_sources_test.sv */
// Self-checking testbench of the stop wake event sources
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; $display("BAD %s expected %h seen %h", nm, ex, got); end end
module stop_wake_event_sources_test;
	import wake_pkg::*;
	typedef struct packed {
		logic [2:0] code;
		logic       level;
		logic [7:0] port2;
		logic [3:0] port3;
		logic       port0_pin0;
		logic       port0_pin7;
		logic       wake;
	} row_t;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, stop_active, wake_event, irq;
	logic [7:0]  port2_pin_in, port2_pin_out, port2_pin_oe, board_port2;
	logic [3:0]  port3_pin_in, board_p3;
	logic        port0_pin0_in, port0_pin7_in, board_port0_pin0, board_port0_pin7;
	int          failures, compares;
	row_t        rows [16] = '{
		'{3'h0, 1'b0, 8'h00, 4'h0, 1'b0, 1'b0, 1'b0},
		'{3'h1, 1'b0, 8'h0F, 4'h0, 1'b0, 1'b0, 1'b1},
		'{3'h1, 1'b0, 8'h0E, 4'h0, 1'b0, 1'b0, 1'b0},
		'{3'h1, 1'b1, 8'h0E, 4'h0, 1'b0, 1'b0, 1'b1},
		'{3'h2, 1'b0, 8'hFF, 4'h0, 1'b0, 1'b0, 1'b1},
		'{3'h2, 1'b0, 8'h7F, 4'h0, 1'b0, 1'b0, 1'b0},
		'{3'h3, 1'b1, 8'h00, 4'h0, 1'b0, 1'b0, 1'b1},
		'{3'h3, 1'b1, 8'h00, 4'h4, 1'b0, 1'b0, 1'b0},
		'{3'h4, 1'b0, 8'h00, 4'hE, 1'b0, 1'b0, 1'b1},
		'{3'h4, 1'b0, 8'h00, 4'hC, 1'b0, 1'b0, 1'b0},
		'{3'h5, 1'b1, 8'h00, 4'h0, 1'b0, 1'b0, 1'b1},
		'{3'h5, 1'b1, 8'h00, 4'h0, 1'b0, 1'b1, 1'b0},
		'{3'h6, 1'b0, 8'h00, 4'hE, 1'b1, 1'b1, 1'b1},
		'{3'h6, 1'b0, 8'h00, 4'hE, 1'b0, 1'b1, 1'b0},
		'{3'h7, 1'b0, 8'h07, 4'hE, 1'b0, 1'b0, 1'b1},
		'{3'h7, 1'b0, 8'h03, 4'hE, 1'b0, 1'b0, 1'b0}
	};

	stop_wake_event_sources u_stop_wake_event_sources (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port2_pin_in(port2_pin_in), .port3_pin_in(port3_pin_in),
		.port0_pin0_in(port0_pin0_in), .port0_pin7_in(port0_pin7_in),
		.port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
		.stop_active(stop_active), .wake_event(wake_event), .irq(irq)
	);

	port_pin_board u_port_pin_board (
		.port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
		.board_port2(board_port2), .board_p3(board_p3),
		.board_port0_pin0(board_port0_pin0), .board_port0_pin7(board_port0_pin7),
		.port2_pin_in(port2_pin_in), .port3_pin_in(port3_pin_in),
		.port0_pin0_in(port0_pin0_in), .port0_pin7_in(port0_pin7_in)
	);

	always #2.5 pclk = ~pclk;

	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask

	task automatic pins(input logic [7:0] port2, input logic [3:0] port3, input logic pin0, pin7);
		@(posedge pclk);
		board_port2 <= port2;
		board_p3 <= port3;
		board_port0_pin0 <= pin0;
		board_port0_pin7 <= pin7;
	endtask

	task automatic settle();
		repeat (4) @(posedge pclk);
		#1;
	endtask

	task automatic wrap_up();
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#50000;
		failures++;
		wrap_up();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		board_port2 = 8'h00;
		board_p3 = 4'h0;
		{board_port0_pin0, board_port0_pin7} = 2'b00;
		failures = 0;
		compares = 0;
		repeat (2) @(posedge pclk);
		#1;
		`CHK("oe in reset", 8'h00, port2_pin_oe)
		`CHK("wake in reset", 1'b0, wake_event)
		@(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			pins(rows[i].port2, rows[i].port3, rows[i].port0_pin0, rows[i].port0_pin7);
			wr(ADDR_LOGIC_SELECT, {1'b0, rows[i].level, 1'b1, rows[i].code, 2'b00});
			settle();
			`CHK("row wake", rows[i].wake, wake_event)
		end
		// Register access kinds and an unmapped place
		wr(ADDR_LOGIC_SELECT, 8'h20);
		xfer(1'b0, ADDR_PORT2_SELECT, 32'h0);
		`CHK("select reads", 32'h0, rd)
		xfer(1'b0, 16'h0000, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		// Per-pin compare source, default and latched references
		wr(ADDR_PORT2_DIRECTION, 8'hFF);
		pins(8'h7F, 4'h0, 1'b0, 1'b0);
		wr(ADDR_PORT2_SELECT, 8'h80);
		settle();
		`CHK("pin7 low", 1'b1, wake_event)
		pins(8'hFE, 4'h0, 1'b0, 1'b0);
		settle();
		`CHK("pin0 unselected", 1'b0, wake_event)
		wr(ADDR_PORT2_SELECT, 8'h01);
		settle();
		`CHK("default zero", 1'b1, wake_event)
		wr(ADDR_PORT2_DATA, 8'h00);
		xfer(1'b0, ADDR_REFERENCE_STATUS, 32'h0);
		`CHK("status write", 2'h2, rd[1:0])
		settle();
		`CHK("equal ref", 1'b0, wake_event)
		pins(8'hFF, 4'h0, 1'b0, 1'b0);
		settle();
		`CHK("differs ref", 1'b1, wake_event)
		xfer(1'b0, ADDR_PORT2_DATA, 32'h0);
		`CHK("data read", 8'hFF, rd[7:0])
		xfer(1'b0, ADDR_REFERENCE_STATUS, 32'h0);
		`CHK("status read", 2'h1, rd[1:0])
		settle();
		`CHK("read ref", 1'b0, wake_event)
		wr(ADDR_PORT2_DATA, 8'hFE);
		settle();
		`CHK("rewrite ref", 1'b1, wake_event)
		`CHK("pin latch", 8'hFE, port2_pin_out)
		wr(ADDR_REFERENCE_STATUS, 8'h00);
		xfer(1'b0, ADDR_REFERENCE_STATUS, 32'h0);
		`CHK("status clear", 2'h0, rd[1:0])
		settle();
		`CHK("default back", 1'b0, wake_event)
		// Exclusion of driven port 2 pins and port 3 select pins
		wr(ADDR_PORT2_SELECT, 8'h00);
		pins(8'h0E, 4'h0, 1'b0, 1'b0);
		wr(ADDR_PORT2_DIRECTION, 8'hFE);
		wr(ADDR_LOGIC_SELECT, 8'h24);
		settle();
		`CHK("oe pin0", 8'h01, port2_pin_oe)
		`CHK("output excluded", 1'b1, wake_event)
		wr(ADDR_PORT2_DIRECTION, 8'hFF);
		pins(8'h00, 4'hC, 1'b0, 1'b0);
		wr(ADDR_LOGIC_SELECT, 8'h30);
		settle();
		`CHK("p3 included", 1'b0, wake_event)
		wr(ADDR_PORT3_SELECT, 8'h02);
		settle();
		`CHK("p3 excluded", 1'b1, wake_event)
		wr(ADDR_PORT3_SELECT, 8'h00);
		// Stop entry and recovery from either source
		pins(8'hFF, 4'h0, 1'b0, 1'b0);
		wr(ADDR_PORT2_SELECT, 8'h01);
		wr(ADDR_LOGIC_SELECT, 8'h64);
		wr(ADDR_IRQ_STATUS, 8'h03);
		wr(ADDR_IRQ_MASK, 8'h00);
		wr(ADDR_STOP_CONTROL, 8'h01);
		settle();
		`CHK("stopped", 1'b1, stop_active)
		pins(8'hF7, 4'h0, 1'b0, 1'b0);
		settle();
		`CHK("logic recovers", 1'b0, stop_active)
		`CHK("irq masked", 1'b0, irq)
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
		`CHK("irq status", 1'b1, rd[IRQ_RECOVERY_BIT])
		xfer(1'b0, ADDR_STOP_CONTROL, 32'h0);
		`CHK("stop flag", 1'b1, rd[STOP_FLAG_BIT])
		wr(ADDR_IRQ_MASK, 8'h01);
		settle();
		`CHK("irq up", 1'b1, irq)
		pins(8'hFF, 4'h0, 1'b0, 1'b0);
		wr(ADDR_IRQ_STATUS, 8'h01);
		settle();
		`CHK("irq cleared", 1'b0, irq)
		wr(ADDR_STOP_CONTROL, 8'h01);
		pins(8'hFE, 4'h0, 1'b0, 1'b0);
		settle();
		`CHK("pin recovers", 1'b0, stop_active)
		pins(8'hF7, 4'h0, 1'b0, 1'b0);
		settle();
		`CHK("logic kept", 1'b1, wake_event)
		// Reset in mid-run clears both select registers
		@(posedge pclk);
		presetn <= 1'b0;
		pins(8'h00, 4'h0, 1'b0, 1'b0);
		#1;
		`CHK("irq reset", 1'b0, irq)
		@(posedge pclk);
		presetn <= 1'b1;
		settle();
		`CHK("selects reset", 1'b0, wake_event)
		xfer(1'b0, ADDR_STOP_CONTROL, 32'h0);
		`CHK("flag reset", 1'b0, rd[STOP_FLAG_BIT])
		wrap_up();
	end
endmodule // stop_wake_event_sources_test

/* core/pin_sync.sv */
// Two flip-flop synchroniser for a group of port input pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] first_stage;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_stage  <= '0;
			pin_sync_out <= '0;
		end else begin
			first_stage  <= pin_in;
			pin_sync_out <= first_stage;
		end
	end
endmodule // pin_sync

/* core/stop_wake_event_sources.sv */
// Stop wake event sources with APB register access and port 2 pin control
//
// Notes on behaviour
// RULE_01 - One select bit per port 2 pin
// RULE_02 - No reference: selected pin wakes on low
// RULE_03 - Port 2 data access latches the reference (code latches only while a port 2 select bit is set)
// RULE_04 - Selected pin differing from reference wakes
// RULE_05 - Status reads 01 after read, 10 after write
// RULE_06 - Writing 00 to status restores default
// RULE_07 - Software makes pin input before selecting it
// RULE_08 - Port 2 select write-only, power-on zero, kept
// RULE_09 - Three-bit source field, code 000 selects none
// RULE_10 - Wake when source output equals level bit
// RULE_11 - Codes 001/010 NAND port 2 pins
// RULE_12 - Codes 011/100 NOR/NAND port 3 pins
// RULE_13 - Codes 101/110 add port 0 pins 0,7
// RULE_14 - Source ignores output or compare-selected pins
// RULE_15 - Any selected source causes stop recovery
// RULE_16 - Software writes fixed values to reserved bits
// RULE_17 - Logic select resets zero, kept on recovery
// RULE_18 - Code 111 NANDs port 3 with port 2 low
`timescale 1ns/100ps
module stop_wake_event_sources
	import wake_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  port2_pin_in,
	input  wire logic [3:0]  port3_pin_in,
	input  wire logic        port0_pin0_in,
	input  wire logic        port0_pin7_in,
	output logic      [7:0]  port2_pin_out,
	output logic      [7:0]  port2_pin_oe,
	output logic             stop_active,
	output logic             wake_event,
	output logic             irq
);
	logic [7:0]  stop_wake_port2_select;
	logic [3:0]  stop_wake_port3_select;
	logic [2:0]  logic_code;
	logic        logic_level;
	logic [1:0]  stop_wake_reference_status;
	logic [7:0]  reference_value;
	logic [7:0]  port2_direction_setting;
	logic [1:0]  irq_status;
	logic [1:0]  irq_mask;
	logic        stop_flag;
	stop_state_t stop_state;

	logic [7:0]  port2_sync;
	logic [3:0]  port3_sync;
	logic [1:0]  port0_sync;
	logic        logic_out;
	logic [7:0]  pin_wake;
	logic        logic_wake;
	logic        any_wake;
	logic        access;
	logic        wr_access;
	logic        rd_access;
	logic        port2_access;
	logic        ref_latch;
	logic        recovery;
	logic [7:0]  port2_read_value;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	// Pin synchronisers
	pin_sync #(.WIDTH(8)) u_sync_p2 (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_in       (port2_pin_in),
		.pin_sync_out (port2_sync)
	);

	pin_sync #(.WIDTH(4)) u_sync_p3 (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_in       (port3_pin_in),
		.pin_sync_out (port3_sync)
	);

	pin_sync #(.WIDTH(2)) u_sync_p0 (
		.pclk         (pclk),
		.presetn      (presetn),
		.pin_in       ({port0_pin7_in, port0_pin0_in}),
		.pin_sync_out (port0_sync)
	);

	// Bus decode
	assign access    = psel & penable & pready;
	assign wr_access = access & pwrite;
	assign rd_access = access & ~pwrite;
	assign port2_access = access & (paddr == ADDR_PORT2_DATA);
	assign ref_latch    = port2_access & (|stop_wake_port2_select); // RULE_03

	// Input pins read the pin, output pins read the output latch
	assign port2_read_value = (port2_sync & port2_direction_setting)
		| (port2_pin_out & ~port2_direction_setting);

	// Per-pin reference compare
	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_pin
			always_comb begin
				if (!stop_wake_port2_select[n]) begin
					pin_wake[n] = 1'b0; // RULE_01
				end else if (stop_wake_reference_status == REF_NONE) begin
					pin_wake[n] = ~port2_sync[n]; // RULE_02
				end else begin
					pin_wake[n] = port2_sync[n] ^ reference_value[n]; // RULE_04
				end
			end
		end
	endgenerate

	// Logic source
	wake_logic_source u_logic (
		.code           (logic_code),
		.port2_pins     (port2_sync),
		.port3_pins     (port3_sync[3:1]),
		.port0_pin0     (port0_sync[0]),
		.port0_pin7     (port0_sync[1]),
		.port2_excluded (~port2_direction_setting | stop_wake_port2_select),
		.port3_excluded (stop_wake_port3_select[3:1]),
		.logic_out      (logic_out)
	);

	assign logic_wake = (logic_code != SRC_NONE) && (logic_out == logic_level); // RULE_09 RULE_10
	assign any_wake   = (|pin_wake) | logic_wake; // RULE_15
	assign recovery   = (stop_state == STOPPED) & wake_event;

	// Read data and error decided in the setup phase
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		case (paddr)
			ADDR_PORT2_SELECT:     next_prdata = 32'h0000_0000;
			ADDR_LOGIC_SELECT:     next_prdata = 32'h0000_0000;
			ADDR_PORT3_SELECT:     next_prdata = 32'h0000_0000;
			ADDR_REFERENCE_STATUS: next_prdata = {30'h0, stop_wake_reference_status};
			ADDR_PORT2_DATA:       next_prdata = {24'h0, port2_read_value};
			ADDR_PORT2_DIRECTION:  next_prdata = {24'h0, port2_direction_setting};
			ADDR_STOP_CONTROL: begin
				next_prdata[STOP_FLAG_BIT]    = stop_flag;
				next_prdata[STOP_WAKE_BIT]    = wake_event;
				next_prdata[STOP_REQUEST_BIT] = stop_active;
			end
			ADDR_IRQ_STATUS:       next_prdata = {30'h0, irq_status};
			ADDR_IRQ_MASK:         next_prdata = {30'h0, irq_mask};
			default:               next_pslverr = 1'b1;
		endcase
	end

	// APB answer: ready in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
				pslverr <= next_pslverr;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Wake select registers, reset clears them, only bus writes change them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_wake_port2_select <= RST_PORT2_SELECT; // RULE_08
			stop_wake_port3_select <= RST_PORT3_SELECT;
			logic_code             <= RST_LOGIC_CODE; // RULE_17
			logic_level            <= RST_LOGIC_LEVEL; // RULE_17
		end else if (wr_access) begin
			if (paddr == ADDR_PORT2_SELECT) begin
				stop_wake_port2_select <= pwdata[7:0]; // RULE_01
			end
			if (paddr == ADDR_PORT3_SELECT) begin
				stop_wake_port3_select <= pwdata[3:0];
			end
			if (paddr == ADDR_LOGIC_SELECT) begin
				logic_code  <= pwdata[LOGIC_CODE_MSB:LOGIC_CODE_LSB]; // RULE_09
				logic_level <= pwdata[LOGIC_LEVEL_BIT]; // RULE_10
			end
		end
	end

	// Reference value and its status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_wake_reference_status <= REF_NONE;
			reference_value            <= 8'h00;
		end else if (ref_latch) begin
			reference_value            <= pwrite ? pwdata[7:0] : prdata[7:0]; // RULE_03
			stop_wake_reference_status <= pwrite ? REF_WRITE : REF_READ; // RULE_05
		end else if (wr_access && paddr == ADDR_REFERENCE_STATUS
			&& pwdata[1:0] == REF_NONE) begin
			stop_wake_reference_status <= REF_NONE; // RULE_06
		end
	end

	// Port 2 output latch and direction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port2_pin_out           <= RST_PORT2_DATA;
			port2_direction_setting <= RST_PORT2_DIRECTION;
			port2_pin_oe            <= ~RST_PORT2_DIRECTION;
		end else if (wr_access) begin
			if (paddr == ADDR_PORT2_DATA) begin
				port2_pin_out <= pwdata[7:0];
			end
			if (paddr == ADDR_PORT2_DIRECTION) begin
				port2_direction_setting <= pwdata[7:0];
				port2_pin_oe            <= ~pwdata[7:0];
			end
		end
	end

	// Wake event register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_event <= 1'b0;
		end else begin
			wake_event <= any_wake; // RULE_15
		end
	end

	// Stop state: software enters stop, any wake event recovers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_state  <= RUNNING;
			stop_active <= 1'b0;
			stop_flag   <= 1'b0;
		end else begin
			case (stop_state)
				RUNNING: begin
					if (wr_access && paddr == ADDR_STOP_CONTROL && pwdata[STOP_REQUEST_BIT]) begin
						stop_state  <= STOPPED;
						stop_active <= 1'b1;
					end
				end
				STOPPED: begin
					if (wake_event) begin
						stop_state  <= RUNNING; // RULE_15
						stop_active <= 1'b0;
						stop_flag   <= 1'b1;
					end
				end
				default: begin
					stop_state  <= RUNNING;
					stop_active <= 1'b0;
				end
			endcase
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= RST_IRQ;
			irq_mask   <= RST_IRQ;
		end else begin
			if (wr_access && paddr == ADDR_IRQ_STATUS) begin
				irq_status <= (irq_status & ~pwdata[1:0])
					| {ref_latch, recovery};
			end else begin
				irq_status <= irq_status | {ref_latch, recovery};
			end
			if (wr_access && paddr == ADDR_IRQ_MASK) begin
				irq_mask <= pwdata[1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// Assertions
	property p_default_low;
		@(posedge pclk) disable iff (!presetn)
		(stop_wake_reference_status == REF_NONE && (stop_wake_port2_select & ~port2_sync) != 8'h00)
		|=> wake_event;
	endproperty
	a_default_low: assert property (p_default_low) // RULE_02
		else $error("selected low pin gave no wake");

	property p_write_latch;
		@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == ADDR_PORT2_DATA && stop_wake_port2_select != 8'h00)
		|=> (stop_wake_reference_status == REF_WRITE && reference_value == $past(pwdata[7:0]));
	endproperty
	a_write_latch: assert property (p_write_latch) // RULE_03
		else $error("write did not latch reference");

	property p_read_latch;
		@(posedge pclk) disable iff (!presetn)
		(rd_access && paddr == ADDR_PORT2_DATA && stop_wake_port2_select != 8'h00)
		|=> (stop_wake_reference_status == REF_READ && reference_value == $past(prdata[7:0]));
	endproperty
	a_read_latch: assert property (p_read_latch) // RULE_05
		else $error("read did not latch reference");

	property p_status_clear;
		@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == ADDR_REFERENCE_STATUS && pwdata[1:0] == 2'h0)
		|=> stop_wake_reference_status == REF_NONE;
	endproperty
	a_status_clear: assert property (p_status_clear) // RULE_06
		else $error("status clear ignored");

	property p_compare;
		@(posedge pclk) disable iff (!presetn)
		(stop_wake_reference_status != REF_NONE
			&& (stop_wake_port2_select & (port2_sync ^ reference_value)) != 8'h00)
		|=> wake_event;
	endproperty
	a_compare: assert property (p_compare) // RULE_04
		else $error("pin differing from reference gave no wake");

	property p_no_source;
		@(posedge pclk) disable iff (!presetn)
		(logic_code == 3'h0 && pin_wake == 8'h00) |=> !wake_event;
	endproperty
	a_no_source: assert property (p_no_source) // RULE_09
		else $error("wake without any source");

	property p_level_match;
		@(posedge pclk) disable iff (!presetn)
		(logic_code != 3'h0 && logic_out == logic_level) |=> wake_event;
	endproperty
	a_level_match: assert property (p_level_match) // RULE_10
		else $error("logic level match gave no wake");

	property p_recover;
		@(posedge pclk) disable iff (!presetn)
		(stop_active && wake_event) |=> (!stop_active && stop_flag && irq_status[0]);
	endproperty
	a_recover: assert property (p_recover) // RULE_15
		else $error("wake did not end stop");

	property p_select_kept;
		@(posedge pclk) disable iff (!presetn)
		(stop_active && wake_event && !wr_access)
		|=> ($stable(stop_wake_port2_select) && $stable(logic_code) && $stable(logic_level));
	endproperty
	a_select_kept: assert property (p_select_kept) // RULE_08
		else $error("recovery changed wake selection");

	c_pin_wake: cover property (@(posedge pclk) disable iff (!presetn)
		stop_active && |pin_wake ##2 !stop_active);
	c_logic_wake: cover property (@(posedge pclk) disable iff (!presetn)
		stop_active && logic_wake ##2 !stop_active);
	c_ref_write: cover property (@(posedge pclk) disable iff (!presetn)
		stop_wake_reference_status == REF_WRITE);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);

endmodule // stop_wake_event_sources

/* core/wake_logic_source.sv */
// Selectable NAND/NOR combination of port pins for the logic wake source
`timescale 1ns/100ps
module wake_logic_source
	import wake_pkg::*;
(
	input  wire logic [2:0] code,
	input  wire logic [7:0] port2_pins,
	input  wire logic [3:1] port3_pins,
	input  wire logic       port0_pin0,
	input  wire logic       port0_pin7,
	input  wire logic [7:0] port2_excluded,
	input  wire logic [3:1] port3_excluded,
	output logic            logic_out
);
	logic [7:0] port2_nand;
	logic [3:1] p3_nand;
	logic [3:1] p3_nor;

	// Excluded pins are forced to the neutral value of each gate
	assign port2_nand = port2_pins | port2_excluded; // RULE_14
	assign p3_nand = port3_pins | port3_excluded; // RULE_14
	assign p3_nor  = port3_pins & ~port3_excluded; // RULE_14

	always_comb begin
		case (code)
			SRC_NAND_PORT2_LOW: logic_out = ~&port2_nand[3:0]; // RULE_11
			SRC_NAND_PORT2_ALL: logic_out = ~&port2_nand; // RULE_11
			SRC_NOR_P3:         logic_out = ~|p3_nor; // RULE_12
			SRC_NAND_P3:        logic_out = ~&p3_nand; // RULE_12
			SRC_NOR_P3_P0:      logic_out = ~|{p3_nor, port0_pin0, port0_pin7}; // RULE_13
			SRC_NAND_P3_P0:     logic_out = ~&{p3_nand, port0_pin0, port0_pin7}; // RULE_13
			SRC_NAND_P3_P2LOW:  logic_out = ~&{p3_nand, port2_nand[2:0]}; // RULE_18
			default:            logic_out = 1'b0;
		endcase
	end
endmodule // wake_logic_source

/* core/wake_pkg.sv */
// Register map, field layout, reset values and encodings of the stop wake block
package wake_pkg;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_REFERENCE_STATUS = 16'h0F0A;
	localparam logic [15:0] IDX_PORT2_SELECT     = 16'h0F0C;
	localparam logic [15:0] IDX_LOGIC_SELECT     = 16'h0F0D;
	localparam logic [15:0] IDX_PORT3_SELECT     = 16'h0F0E;
	localparam logic [15:0] IDX_PORT2_DATA       = 16'h0F10;
	localparam logic [15:0] IDX_PORT2_DIRECTION  = 16'h0F11;
	localparam logic [15:0] IDX_STOP_CONTROL     = 16'h0F12;
	localparam logic [15:0] IDX_IRQ_STATUS       = 16'h0F13;
	localparam logic [15:0] IDX_IRQ_MASK         = 16'h0F14;

	localparam logic [15:0] ADDR_REFERENCE_STATUS = 16'(IDX_REFERENCE_STATUS * 4);
	localparam logic [15:0] ADDR_PORT2_SELECT     = 16'(IDX_PORT2_SELECT * 4);
	localparam logic [15:0] ADDR_LOGIC_SELECT     = 16'(IDX_LOGIC_SELECT * 4);
	localparam logic [15:0] ADDR_PORT3_SELECT     = 16'(IDX_PORT3_SELECT * 4);
	localparam logic [15:0] ADDR_PORT2_DATA       = 16'(IDX_PORT2_DATA * 4);
	localparam logic [15:0] ADDR_PORT2_DIRECTION  = 16'(IDX_PORT2_DIRECTION * 4);
	localparam logic [15:0] ADDR_STOP_CONTROL     = 16'(IDX_STOP_CONTROL * 4);
	localparam logic [15:0] ADDR_IRQ_STATUS       = 16'(IDX_IRQ_STATUS * 4);
	localparam logic [15:0] ADDR_IRQ_MASK         = 16'(IDX_IRQ_MASK * 4);

	// Field positions
	localparam int LOGIC_LEVEL_BIT   = 6;
	localparam int LOGIC_CODE_LSB    = 2;
	localparam int LOGIC_CODE_MSB    = 4;
	localparam int STOP_REQUEST_BIT  = 0;
	localparam int STOP_WAKE_BIT     = 1;
	localparam int STOP_FLAG_BIT     = 7;
	localparam int IRQ_RECOVERY_BIT  = 0;
	localparam int IRQ_REFERENCE_BIT = 1;

	// Reset values
	localparam logic [7:0] RST_PORT2_SELECT    = 8'h00;
	localparam logic [3:0] RST_PORT3_SELECT    = 4'h0;
	localparam logic [2:0] RST_LOGIC_CODE      = 3'h0;
	localparam logic       RST_LOGIC_LEVEL     = 1'b0;
	localparam logic [7:0] RST_PORT2_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_PORT2_DATA      = 8'h00;
	localparam logic [1:0] RST_IRQ             = 2'h0;

	// Reference status encodings
	localparam logic [1:0] REF_NONE  = 2'h0;
	localparam logic [1:0] REF_READ  = 2'h1;
	localparam logic [1:0] REF_WRITE = 2'h2;

	// Logic source codes
	localparam logic [2:0] SRC_NONE           = 3'h0;
	localparam logic [2:0] SRC_NAND_PORT2_LOW = 3'h1;
	localparam logic [2:0] SRC_NAND_PORT2_ALL = 3'h2;
	localparam logic [2:0] SRC_NOR_P3         = 3'h3;
	localparam logic [2:0] SRC_NAND_P3        = 3'h4;
	localparam logic [2:0] SRC_NOR_P3_P0      = 3'h5;
	localparam logic [2:0] SRC_NAND_P3_P0     = 3'h6;
	localparam logic [2:0] SRC_NAND_P3_P2LOW  = 3'h7;

	typedef enum logic {
		RUNNING = 1'b0,
		STOPPED = 1'b1
	} stop_state_t;

endpackage
